// ===== rtl/clock_prescaler_power_modes.v
// Clock prescalers, operating mode state and module standby gating
`timescale 1ns/1ns
`include "clk_presc_map.vh"

// Overview of operation
// - 13-bit system prescaler counts each clock
// - Reset clears system prescaler, then counts
// - Standby or subclock modes hold prescaler cleared
// - System prescaler count invisible to software
// - Shared taps, clock/2 down to /8192
// - Active divide select gates prescaler input
// - 5-bit subclock prescaler fed subclock/4
// - Subclock taps /8 to /128, time base
// - Reset clears subclock prescaler, then counts
// - Subclock prescaler runs in low modes
// - Both time-base mode bits clear prescaler
// - Subactive CPU clock subclock /2,/4,/8
// - Sleep stops CPU, peripherals on system
// - Subsleep stops CPU, peripherals on subclock
// - Standby halts all but time base
// - Module standby gates each peripheral clock
// - Standby select steers sleep entry
module clock_prescaler_power_modes #(
  parameter NUM_MODULES = 8
) (
  input  wire                   clk_sys_i,
  input  wire                   rst_i,
  input  wire                   ce_i,
  input  wire                   sub_tick_i,
  input  wire                   sleep_req_i,
  input  wire                   wake_req_i,
  input  wire                   psel_i,
  input  wire                   penable_i,
  input  wire                   pwrite_i,
  input  wire [11:0]            paddr_i,
  input  wire [31:0]            pwdata_i,
  output wire                   pready_o,
  output wire                   pslverr_o,
  output reg  [31:0]            prdata_o,
  output reg  [12:0]            sys_tap_en_o,
  output reg  [4:0]             sub_tap_en_o,
  output reg                    cpu_clk_en_o,
  output reg                    periph_sys_en_o,
  output reg                    periph_sub_en_o,
  output reg  [NUM_MODULES-1:0] module_clk_en_o,
  output reg                    time_base_en_o,
  output reg  [2:0]             mode_o
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0]                    sys_ctrl_one_r;
  reg [7:0]                    system_control_two_r;
  reg [NUM_MODULES-1:0]        module_standby_r;
  reg [7:0]                    time_base_timer_mode_register_r;
  reg [2:0]                    mode_r;
  reg [2:0]                    mode_nxt;
  reg [`SYS_PRESC_WIDTH-1:0]   sys_presc_r;
  reg [`SUB_PRESC_WIDTH-1:0]   sub_presc_r;
  reg [1:0]                    sub_pre_r;
  reg [6:0]                    div_cnt_r;
  reg [2:0]                    cpu_sub_cnt_r;
  reg                          sleep_cmd_r;
  reg                          wake_cmd_r;

  wire       wr_en = psel_i & penable_i & pwrite_i & ce_i;
  wire       sub_quarter = sub_tick_i & (sub_pre_r == 2'h3);
  wire       sys_running = (mode_r == `MODE_ACTIVE) | (mode_r == `MODE_SLEEP);
  wire [2:0] div_sel = system_control_two_r[`FLD_DIV_SELECT_HI:`FLD_DIV_SELECT_LO];
  wire       tb_clear = wr_en & (paddr_i == `OFS_TIME_BASE_MODE)
                        & pwdata_i[`BIT_TIME_BASE_MODE3] & pwdata_i[`BIT_TIME_BASE_MODE2];
  reg        div_tick;
  reg        cpu_sub_tick;

  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  // --------------------------------------------------------------------------
  // Active clock divide: select 0 passes every clock, n passes 1 of 2^n
  // --------------------------------------------------------------------------
  always @* begin
    case (div_sel)
      3'h0:    div_tick = 1'b1;
      3'h1:    div_tick = (div_cnt_r[0] == 1'b0);
      3'h2:    div_tick = (div_cnt_r[1:0] == 2'h0);
      3'h3:    div_tick = (div_cnt_r[2:0] == 3'h0);
      3'h4:    div_tick = (div_cnt_r[3:0] == 4'h0);
      3'h5:    div_tick = (div_cnt_r[4:0] == 5'h00);
      3'h6:    div_tick = (div_cnt_r[5:0] == 6'h00);
      default: div_tick = (div_cnt_r[6:0] == 7'h00);
    endcase
  end

  // Subactive CPU clock: subclock /2, /4 or /8 from the low divide bits
  always @* begin
    case (div_sel[1:0])
      2'h0:    cpu_sub_tick = sub_tick_i & (cpu_sub_cnt_r[0] == 1'b1);
      2'h1:    cpu_sub_tick = sub_tick_i & (cpu_sub_cnt_r[1:0] == 2'h3);
      default: cpu_sub_tick = sub_tick_i & (cpu_sub_cnt_r[2:0] == 3'h7);
    endcase
  end

  // --------------------------------------------------------------------------
  // Mode state machine
  // --------------------------------------------------------------------------
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      `MODE_ACTIVE, `MODE_SUBACTIVE: begin
        if (sleep_req_i | sleep_cmd_r) begin
          if (sys_ctrl_one_r[`BIT_STANDBY_SELECT])
            mode_nxt = `MODE_STANDBY;
          else if (mode_r == `MODE_SUBACTIVE)
            mode_nxt = `MODE_SUBSLEEP;
          else
            mode_nxt = `MODE_SLEEP;
        end else if (mode_r == `MODE_ACTIVE && system_control_two_r[`BIT_SUB_SELECT])
          mode_nxt = `MODE_SUBACTIVE;
        else if (mode_r == `MODE_SUBACTIVE && !system_control_two_r[`BIT_SUB_SELECT])
          mode_nxt = `MODE_ACTIVE;
      end
      `MODE_SLEEP, `MODE_SUBSLEEP, `MODE_STANDBY: begin
        // Wake returns to the run mode that the subclock select names
        if (wake_req_i | wake_cmd_r)
          mode_nxt = system_control_two_r[`BIT_SUB_SELECT] ? `MODE_SUBACTIVE : `MODE_ACTIVE;
      end
      default: mode_nxt = `MODE_ACTIVE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Register writes, counters and mode
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sys_ctrl_one_r                  <= `RST_SYSTEM_CONTROL_ONE;
      system_control_two_r            <= `RST_SYSTEM_CONTROL_TWO;
      module_standby_r                <= {NUM_MODULES{1'b0}};
      time_base_timer_mode_register_r <= `RST_TIME_BASE_MODE;
      mode_r                          <= `MODE_ACTIVE;
      sys_presc_r                     <= 13'h0000;
      sub_presc_r                     <= 5'h00;
      sub_pre_r                       <= 2'h0;
      div_cnt_r                       <= 7'h00;
      cpu_sub_cnt_r                   <= 3'h0;
      sleep_cmd_r                     <= 1'b0;
      wake_cmd_r                      <= 1'b0;
    end else if (ce_i) begin
      mode_r      <= mode_nxt;
      sleep_cmd_r <= wr_en & (paddr_i == `OFS_MODE_COMMAND) & pwdata_i[`BIT_CMD_SLEEP];
      wake_cmd_r  <= wr_en & (paddr_i == `OFS_MODE_COMMAND) & pwdata_i[`BIT_CMD_WAKE];
      if (wr_en) begin
        case (paddr_i)
          `OFS_SYSTEM_CONTROL_ONE: sys_ctrl_one_r <= pwdata_i[7:0];
          `OFS_SYSTEM_CONTROL_TWO: system_control_two_r <= pwdata_i[7:0];
          `OFS_MODULE_STANDBY:     module_standby_r <= pwdata_i[NUM_MODULES-1:0];
          `OFS_TIME_BASE_MODE:     time_base_timer_mode_register_r <= pwdata_i[7:0];
          default: ;
        endcase
      end
      if (!sys_running) begin
        sys_presc_r <= 13'h0000;
        div_cnt_r   <= 7'h00;
      end else begin
        div_cnt_r <= div_cnt_r + 7'h01;
        if (div_tick)
          sys_presc_r <= sys_presc_r + 13'h0001;
      end
      if (sub_tick_i)
        sub_pre_r <= sub_pre_r + 2'h1;
      if (sub_tick_i)
        cpu_sub_cnt_r <= cpu_sub_cnt_r + 3'h1;
      if (tb_clear) begin
        sub_presc_r <= 5'h00;
        sub_pre_r   <= 2'h0;
      end else if (sub_quarter)
        sub_presc_r <= sub_presc_r + 5'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Clock enables and tap pulses, registered so outputs come from flip-flops
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SYS_PRESC_WIDTH; gi = gi + 1) begin : g_sys_tap
      // Tap at /2^(gi+1): falling edge of bit gi
      always @(posedge clk_sys_i) begin
        if (rst_i)
          sys_tap_en_o[gi] <= 1'b0;
        else if (ce_i)
          sys_tap_en_o[gi] <= sys_running & div_tick & (&sys_presc_r[gi:0]);
      end
    end
    for (gi = 0; gi < `SUB_PRESC_WIDTH; gi = gi + 1) begin : g_sub_tap
      always @(posedge clk_sys_i) begin
        if (rst_i)
          sub_tap_en_o[gi] <= 1'b0;
        else if (ce_i)
          sub_tap_en_o[gi] <= sub_quarter & ~tb_clear & (&sub_presc_r[gi:0]);
      end
    end
  endgenerate

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cpu_clk_en_o    <= 1'b0;
      periph_sys_en_o <= 1'b0;
      periph_sub_en_o <= 1'b0;
      module_clk_en_o <= {NUM_MODULES{1'b0}};
      time_base_en_o  <= 1'b0;
      mode_o          <= `MODE_ACTIVE;
      prdata_o        <= 32'h00000000;
    end else if (ce_i) begin
      mode_o <= mode_r;
      cpu_clk_en_o <= (mode_r == `MODE_ACTIVE) ? div_tick :
                      (mode_r == `MODE_SUBACTIVE) ? cpu_sub_tick : 1'b0;
      periph_sys_en_o <= sys_running & div_tick;
      periph_sub_en_o <= sub_tick_i & ((mode_r == `MODE_SUBACTIVE) |
                                       (mode_r == `MODE_SUBSLEEP));
      module_clk_en_o <= {NUM_MODULES{(mode_r != `MODE_STANDBY)}} & ~module_standby_r;
      time_base_en_o <= time_base_timer_mode_register_r[`BIT_TIME_BASE_ENABLE]
                        | (mode_r != `MODE_STANDBY);
      // No prescaler count in read data
      prdata_o <= 32'h00000000;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        case (paddr_i)
          `OFS_SYSTEM_CONTROL_ONE: prdata_o <= {24'h000000, sys_ctrl_one_r};
          `OFS_SYSTEM_CONTROL_TWO: prdata_o <= {24'h000000, system_control_two_r};
          `OFS_MODULE_STANDBY:     prdata_o[NUM_MODULES-1:0] <= module_standby_r;
          `OFS_TIME_BASE_MODE:     prdata_o <= {24'h000000, time_base_timer_mode_register_r};
          `OFS_MODE_STATUS:        prdata_o <= {29'h00000000, mode_r};
          default:                 prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ===== rtl/clk_presc_map.vh
// Register map, field positions and reset values of the clock prescaler block
`ifndef CLK_PRESC_MAP_VH
`define CLK_PRESC_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_SYSTEM_CONTROL_ONE   12'h000
`define OFS_SYSTEM_CONTROL_TWO   12'h004
`define OFS_MODULE_STANDBY       12'h008
`define OFS_TIME_BASE_MODE       12'h00C
`define OFS_MODE_COMMAND         12'h010
`define OFS_MODE_STATUS          12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_STANDBY_SELECT       7
`define BIT_SUB_SELECT           3
`define FLD_DIV_SELECT_HI        2
`define FLD_DIV_SELECT_LO        0
`define BIT_TIME_BASE_MODE3      3
`define BIT_TIME_BASE_MODE2      2
`define BIT_TIME_BASE_ENABLE     4
`define BIT_CMD_SLEEP            0
`define BIT_CMD_WAKE             1

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define RST_SYSTEM_CONTROL_ONE   8'h00
`define RST_SYSTEM_CONTROL_TWO   8'h00
`define RST_MODULE_STANDBY       8'h00
`define RST_TIME_BASE_MODE       8'h00
`define SYS_PRESC_WIDTH          13
`define SUB_PRESC_WIDTH          5
`define SUB_PRE_DIV              4

// ----------------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------------
`define MODE_ACTIVE              3'h0
`define MODE_SLEEP               3'h1
`define MODE_SUBACTIVE           3'h2
`define MODE_SUBSLEEP            3'h3
`define MODE_STANDBY             3'h4

`endif

// ===== bench/clk_presc_assertions.sv
// Checker for prescaler taps, clock enables and operating mode outputs
`timescale 1ns/1ns
module clk_presc_assertions #(
  parameter NUM_MODULES = 8
) (
  input wire                   clk_sys_i,
  input wire                   rst_i,
  input wire                   sleep_req_i,
  input wire [2:0]             mode_o,
  input wire [12:0]            sys_tap_en_o,
  input wire [4:0]             sub_tap_en_o,
  input wire                   cpu_clk_en_o,
  input wire                   periph_sys_en_o,
  input wire                   periph_sub_en_o,
  input wire [NUM_MODULES-1:0] module_clk_en_o
);
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_sys_halt; (mode_o >= 3'h2) && $stable(mode_o) |-> sys_tap_en_o == 13'h0000; endproperty
  a_sys_halt: assert property (p_sys_halt) else $error("system taps run while halted");
  property p_tap_chain; (sys_tap_en_o[12:1] & ~sys_tap_en_o[11:0]) == 12'h000; endproperty
  a_tap_chain: assert property (p_tap_chain) else $error("slow tap without fast tap");
  property p_sub_chain; (sub_tap_en_o[4:1] & ~sub_tap_en_o[3:0]) == 4'h0; endproperty
  a_sub_chain: assert property (p_sub_chain) else $error("subclock tap chain broken");
  property p_cpu_halt; mode_o inside {3'h1, 3'h3, 3'h4} |-> !cpu_clk_en_o; endproperty
  a_cpu_halt: assert property (p_cpu_halt) else $error("cpu clock runs while halted");
  property p_sleep_go; $rose(sleep_req_i) && mode_o == 3'h0 |-> ##2 mode_o inside {3'h1, 3'h4};
  endproperty
  a_sleep_go: assert property (p_sleep_go) else $error("sleep entry missed");
  property p_stby_gate; mode_o == 3'h4 && $stable(mode_o) |-> module_clk_en_o == '0; endproperty
  a_stby_gate: assert property (p_stby_gate) else $error("module clock in standby");
  property p_sub_src; periph_sub_en_o && $stable(mode_o) |-> mode_o inside {3'h2, 3'h3};
  endproperty
  a_sub_src: assert property (p_sub_src) else $error("subclock peripheral pulse");
  property p_sys_src; periph_sys_en_o && $stable(mode_o) |-> mode_o inside {3'h0, 3'h1};
  endproperty
  a_sys_src: assert property (p_sys_src) else $error("system peripheral pulse");
endmodule

bind clock_prescaler_power_modes clk_presc_assertions #(.NUM_MODULES(NUM_MODULES)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sleep_req_i(sleep_req_i), .mode_o(mode_o),
  .sys_tap_en_o(sys_tap_en_o), .sub_tap_en_o(sub_tap_en_o), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_sys_en_o(periph_sys_en_o), .periph_sub_en_o(periph_sub_en_o),
  .module_clk_en_o(module_clk_en_o));

// ===== bench/periph_model.sv
// Peripheral model that picks one clock tap and times its pulses
`timescale 1ns/1ns
module periph_model (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire [12:0] tap_i,
  input  wire [3:0]  sel_i,
  output reg  [15:0] gap_o,
  output reg  [15:0] hits_o
);
  reg [15:0] run_r;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_r  <= 16'h0000;
      gap_o  <= 16'h0000;
      hits_o <= 16'h0000;
    end else if (tap_i[sel_i]) begin
      gap_o  <= run_r + 16'h0001;
      run_r  <= 16'h0000;
      hits_o <= hits_o + 16'h0001;
    end else begin
      run_r  <= run_r + 16'h0001;
    end
  end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the clock prescaler and power modes
`timescale 1ns/1ns
module testbench;
  reg         clk_sys_i, rst_i, ce, sub_tick, sleep_r, wake_r, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [3:0]  sys_sel, sub_sel;
  reg  [1:0]  tick_cnt;
  reg  [15:0] h, hs;
  integer     error_cnt, n_compared, k;
  wire        pready, pslverr, cpu_en, psys, psub, tb_en;
  wire [31:0] prdata;
  wire [12:0] sys_tap;
  wire [4:0]  sub_tap;
  wire [7:0]  mod_en;
  wire [2:0]  mode;
  wire [15:0] sys_gap, sys_hits, sub_gap, sub_hits, cpu_gap, cpu_hits;
  clock_prescaler_power_modes dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
    .sub_tick_i(sub_tick), .sleep_req_i(sleep_r), .wake_req_i(wake_r), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .sys_tap_en_o(sys_tap),
    .sub_tap_en_o(sub_tap), .cpu_clk_en_o(cpu_en), .periph_sys_en_o(psys),
    .periph_sub_en_o(psub), .module_clk_en_o(mod_en), .time_base_en_o(tb_en), .mode_o(mode));
  periph_model u_sys (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tap_i(sys_tap), .sel_i(sys_sel),
    .gap_o(sys_gap), .hits_o(sys_hits));
  periph_model u_sub (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tap_i({8'h00, sub_tap}),
    .sel_i(sub_sel), .gap_o(sub_gap), .hits_o(sub_hits));
  periph_model u_cpu (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tap_i({12'h000, cpu_en}),
    .sel_i(4'h0), .gap_o(cpu_gap), .hits_o(cpu_hits));
  // ----------------------------------------------------------------------------
  // Clock, subclock ticks and tasks
  // ----------------------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Subclock edge every fourth system clock keeps runs short
  always @(posedge clk_sys_i) begin
    tick_cnt <= tick_cnt + 2'h1;
    sub_tick <= (tick_cnt == 2'h3);
  end
  task wrap_up;
    begin
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r);
    integer n;
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      if (n >= 50) begin
        error_cnt = error_cnt + 1;
        wrap_up;
      end
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task pulse(input s);
    begin
      if (s) sleep_r <= 1'b1;
      else wake_r <= 1'b1;
      @(posedge clk_sys_i);
      sleep_r <= 1'b0; wake_r <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    error_cnt = 0; n_compared = 0; rst_i = 1'b1; ce = 1'b1; sleep_r = 1'b0; wake_r = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h00000000;
    sys_sel = 4'hC; sub_sel = 4'h4; tick_cnt = 2'h0; sub_tick = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (k = 0; k < 6; k = k + 1) begin
      xfer(1'b0, k * 4, 32'h0, q);
      chk(q, 32'h0);
    end
    xfer(1'b0, 12'h0F0, 32'h0, q);
    chk(q, 32'h0);
    repeat (16400) @(posedge clk_sys_i);
    chk(sys_gap, 32'd8192);
    chk(sub_gap, 32'd512);
    xfer(1'b1, 12'h00C, 32'h0000000C, q);
    // Only the first tap pulse after the clear may have been seen
    repeat (700) @(posedge clk_sys_i);
    chk(sub_gap > 16'd512, 32'h1);
    sys_sel = 4'h0;
    for (k = 0; k < 3; k = k + 1) begin
      xfer(1'b1, 12'h004, k, q);
      repeat (40) @(posedge clk_sys_i);
      chk(sys_gap, 32'd2 << k);
    end
    xfer(1'b1, 12'h004, 32'h0, q);
    pulse(1'b1);
    chk(mode, 32'h1);
    h = cpu_hits;
    hs = sys_hits;
    repeat (50) @(posedge clk_sys_i);
    chk(cpu_hits, h);
    chk(sys_hits != hs, 32'h1);
    pulse(1'b0);
    xfer(1'b1, 12'h00C, 32'h00000010, q);
    xfer(1'b1, 12'h000, 32'h00000080, q);
    pulse(1'b1);
    chk(mode, 32'h4);
    chk(mod_en, 32'h0);
    chk(tb_en, 32'h1);
    h = sub_hits;
    hs = sys_hits;
    repeat (600) @(posedge clk_sys_i);
    chk(sub_hits != h, 32'h1);
    chk(sys_hits, hs);
    pulse(1'b0);
    xfer(1'b1, 12'h000, 32'h0, q);
    xfer(1'b1, 12'h008, 32'h000000A5, q);
    // Gate output is registered one edge after the write lands
    @(posedge clk_sys_i);
    chk(mod_en, 32'h5A);
    for (k = 0; k < 3; k = k + 1) begin
      xfer(1'b1, 12'h004, 32'h8 | k, q);
      repeat (120) @(posedge clk_sys_i);
      chk(cpu_gap, 32'd8 << k);
    end
    chk(mode, 32'h2);
    // Sleep through the command register this time
    xfer(1'b1, 12'h010, 32'h00000001, q);
    repeat (3) @(posedge clk_sys_i);
    chk(mode, 32'h3);
    wrap_up;
  end
endmodule
